// ==== hw/audio_dac_regs.vh ====
/*
 * Constants for the audio converter configuration bank: register
 * addresses, reset values, write masks, field positions, serial access
 * layout and the auxiliary pin control register.
 * Assumes it is included by bare name from the files under hw/.
 */
`ifndef AUDIO_DAC_REGS_VH
`define AUDIO_DAC_REGS_VH

// Converter register addresses (7-bit serial address space)
`define ADDR_POWER          7'h00
`define ADDR_LEFT_LINE_IN   7'h01
`define ADDR_RIGHT_LINE_IN  7'h02
`define ADDR_MIXER          7'h08
`define ADDR_CLOCK_RATE     7'h09
`define ADDR_MISC           7'h0a
`define ADDR_AUX_GAIN       7'h0d

// Reset values
`define RST_POWER           8'h00
`define RST_LINE_IN         8'h05
`define RST_MIXER           8'h09
`define RST_CLOCK_RATE      8'h00
`define RST_MISC            8'h00
`define RST_AUX_GAIN        8'h05
`define RST_AUX_PIN         8'hff

// Writable bits; the rest read as zero
`define MASK_POWER          8'hff
`define MASK_GAIN5          8'h1f
`define MASK_MIXER          8'h3f
`define MASK_CLOCK_RATE     8'h10
`define MASK_MISC           8'h3f

// Power control bit positions
`define PWR_MONO_AMP        7
`define PWR_AUX_IN          6
`define PWR_RIGHT_CONV      5
`define PWR_LEFT_CONV       4
`define PWR_RIGHT_LINE_OUT  3
`define PWR_LEFT_LINE_OUT   2
`define PWR_RIGHT_LINE_IN   1
`define PWR_LEFT_LINE_IN    0

// Mixer control bit positions
`define MIX_LEFT_LEFT       0
`define MIX_LEFT_RIGHT      1
`define MIX_RIGHT_LEFT      2
`define MIX_RIGHT_RIGHT     3

// Clock rate and miscellaneous fields
`define OVERSAMPLE_BIT      4
`define WIDTH_LO            0
`define WIDTH_HI            1
`define DEEMPH_BIT          2
`define DITHER_BIT          3
`define FORMAT_LO           4
`define FORMAT_HI           5

// Sample width and format codes
`define WIDTH_16            2'b00
`define WIDTH_18            2'b01
`define WIDTH_20            2'b10
`define FORMAT_I2S          2'b00
`define FORMAT_MSB          2'b01

// Master clock ratios
`define RATIO_256           9'd256
`define RATIO_384           9'd384

// Gain code mapping
`define GAIN_TOP_CODE       5'h00
`define GAIN_TOP_DB         8'h14
`define GAIN_LAST_CODE      5'h10
`define GAIN_BASE_DB        8'h0f
`define GAIN_STEP_DB        8'h03
`define GAIN_FLOOR_DB       8'hc4

// Serial access layout
`define HEAD_BITS           5'd8
`define LAST_BIT            5'd15

// Auxiliary pin control register
`define AUX_PIN_ADDR        8'h90
`define AUX_FROM_DAC_BIT    4
`define AUX_TO_DAC_BIT      3
`define AUX_CLOCK_BIT       2
`define AUX_SELECT_BIT      1

// Synchroniser lanes
`define SYNC_SEL            3
`define SYNC_CLK            2
`define SYNC_DIN            1
`define SYNC_AUX            0
`define SYNC_IDLE           4'hf

`endif

// ==== hw/pin_sync.v ====
/*
 * Three-stage pin synchroniser with agreement filter, one lane per bit.
 * Assumes the inputs are asynchronous to clk and change slowly
 * compared with the clk period.
 */
`timescale 1ns/1ps
`default_nettype none

module pin_sync #(
    parameter WIDTH = 4,
    parameter [WIDTH-1:0] RESET_VAL = {WIDTH{1'b1}}
) (
    input  wire             clk,
    input  wire             rst_n,
    input  wire [WIDTH-1:0] pinIn,
    output wire [WIDTH-1:0] levelOut
);

    reg [WIDTH-1:0] stage1_r;
    reg [WIDTH-1:0] stage2_r;
    reg [WIDTH-1:0] stage3_r;
    reg [WIDTH-1:0] level_r;
    wire [WIDTH-1:0] differ;

    // Only the second and third stages are compared; stage one stays
    // private to the second so metastability cannot leak out
    assign differ = stage2_r ^ stage3_r;
    assign levelOut = level_r;

    always @(posedge clk) begin
        if (!rst_n) begin
            stage1_r <= RESET_VAL;
            stage2_r <= RESET_VAL;
            stage3_r <= RESET_VAL;
            level_r  <= RESET_VAL;
        end else begin
            stage1_r <= pinIn;
            stage2_r <= stage1_r;
            stage3_r <= stage2_r;
            level_r  <= (~differ & stage3_r) | (differ & level_r);
        end
    end

endmodule

`default_nettype wire

// ==== hw/audio_dac_config_regs.v ====
/*
 * Configuration register bank of the embedded stereo audio converter,
 * its four-wire serial slave, and the core's auxiliary pin control
 * register that drives the serial lines.
 * Assumes the bench loops the auxiliary pin outputs back onto the
 * serial slave pins; clk must run during every serial access.
 */
`timescale 1ns/1ps
`default_nettype none
`include "audio_dac_regs.vh"

module audio_dac_config_regs (
    input  wire       clk,
    input  wire       rst_n,
    input  wire       sfrWrEn,
    input  wire [7:0] sfrAddr,
    input  wire [7:0] sfrWdata,
    output wire [7:0] sfrRdata,
    output wire       auxPinClock,
    output wire       auxPinToDac,
    output wire       auxPinSelectN,
    input  wire       auxPinFromDac,
    input  wire       dacSerialClock,
    input  wire       dacSerialIn,
    input  wire       dacSelectN,
    output wire       dacSerialOut,
    output wire       pwrMonoAmpDriver,
    output wire       pwrAuxInput,
    output wire       pwrRightConverter,
    output wire       pwrLeftConverter,
    output wire       pwrRightLineOut,
    output wire       pwrLeftLineOut,
    output wire       pwrRightLineIn,
    output wire       pwrLeftLineIn,
    output wire [4:0] leftLineInGainCode,
    output wire [4:0] rightLineInGainCode,
    output wire [4:0] auxInputGain,
    output wire [7:0] auxGainDb,
    output wire       auxGainFloor,
    output wire       leftMixLeftSrcEn,
    output wire       leftMixRightSrcEn,
    output wire       rightMixLeftSrcEn,
    output wire       rightMixRightSrcEn,
    output wire       leftMixHalfGain,
    output wire       rightMixHalfGain,
    output wire       oversampleRatioSel,
    output wire [8:0] masterClockRatio,
    output wire [1:0] sampleWidthSel,
    output wire [4:0] sampleBits,
    output wire [1:0] audioFormatSel,
    output wire       formatI2s,
    output wire       formatMsbJustified,
    output wire       formatLsbJustified,
    output wire       deemphasisOn,
    output wire       ditherOn
);

    localparam [1:0] ST_IDLE = 2'd0;
    localparam [1:0] ST_HEAD = 2'd1;
    localparam [1:0] ST_DATA = 2'd2;
    localparam [1:0] ST_DONE = 2'd3;

    // Gain code to signed dB; codes past the last step read as the floor
    function [7:0] gainToDb;
        input [4:0] code;
        begin
            if (code == `GAIN_TOP_CODE) begin
                gainToDb = `GAIN_TOP_DB;
            end else if (code <= `GAIN_LAST_CODE) begin
                gainToDb = `GAIN_BASE_DB - `GAIN_STEP_DB * {3'b000, code};
            end else begin
                gainToDb = `GAIN_FLOOR_DB;
            end
        end
    endfunction

    reg  [7:0] auxPin_r;
    reg  [7:0] sfrRdata_r;
    reg  [7:0] power_r;
    reg  [7:0] leftGain_r;
    reg  [7:0] rightGain_r;
    reg  [7:0] mixer_r;
    reg  [7:0] clockRate_r;
    reg  [7:0] misc_r;
    reg  [7:0] auxGain_r;
    reg  [1:0] state_r;
    reg  [1:0] state_nxt;
    reg  [4:0] bitCnt_r;
    reg        readOp_r;
    reg  [6:0] addr_r;
    reg  [7:0] rxShift_r;
    reg  [7:0] txShift_r;
    reg        dout_r;
    reg        prevClk_r;
    reg        prevSel_r;
    reg  [7:0] readWord;
    reg  [7:0] auxDb_r;
    reg        auxFloor_r;
    reg        leftHalf_r;
    reg        rightHalf_r;
    reg  [8:0] ratio_r;
    reg  [4:0] bits_r;
    reg  [2:0] fmtOneHot_r;
    wire [3:0] syncLevel;
    wire       selN;
    wire       sclk;
    wire       sdin;
    wire       clkFall;
    wire       clkRise;
    wire       selRise;
    wire       wrStb;
    wire [7:0] wrData;
    wire [7:0] auxReadBack;

    pin_sync #(
        .WIDTH     (4),
        .RESET_VAL (`SYNC_IDLE)
    ) u_pin_sync (
        .clk      (clk),
        .rst_n    (rst_n),
        .pinIn    ({dacSelectN, dacSerialClock, dacSerialIn, auxPinFromDac}),
        .levelOut (syncLevel)
    );

    assign selN    = syncLevel[`SYNC_SEL];
    assign sclk    = syncLevel[`SYNC_CLK];
    assign sdin    = syncLevel[`SYNC_DIN];
    assign selRise = selN & ~prevSel_r;
    assign clkFall = prevClk_r & ~sclk & ~selN;
    assign clkRise = ~prevClk_r & sclk & ~selN;

    // Core side: the converter lines are plain register bits
    always @(posedge clk) begin
        if (!rst_n) begin
            auxPin_r <= `RST_AUX_PIN;
        end else if (sfrWrEn && sfrAddr == `AUX_PIN_ADDR) begin
            auxPin_r <= sfrWdata;
        end
    end

    // Bit 4 reads the line coming back from the converter
    assign auxReadBack = {auxPin_r[7:`AUX_FROM_DAC_BIT + 1],
                          syncLevel[`SYNC_AUX],
                          auxPin_r[`AUX_FROM_DAC_BIT - 1:0]};

    always @(posedge clk) begin
        if (!rst_n) begin
            sfrRdata_r <= `RST_AUX_PIN;
        end else if (sfrAddr == `AUX_PIN_ADDR) begin
            sfrRdata_r <= auxReadBack;
        end else begin
            sfrRdata_r <= 8'h00;
        end
    end

    assign auxPinClock   = auxPin_r[`AUX_CLOCK_BIT];
    assign auxPinToDac   = auxPin_r[`AUX_TO_DAC_BIT];
    assign auxPinSelectN = auxPin_r[`AUX_SELECT_BIT];

    // Serial slave sequencing
    always @* begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (!selN) begin
                    state_nxt = ST_HEAD;
                end
            end
            ST_HEAD: begin
                if (clkFall && bitCnt_r == `HEAD_BITS - 5'd1) begin
                    state_nxt = ST_DATA;
                end
            end
            ST_DATA: begin
                if (clkFall && bitCnt_r == `LAST_BIT) begin
                    state_nxt = ST_DONE;
                end
            end
            ST_DONE: begin
                state_nxt = ST_DONE;
            end
            default: begin
                state_nxt = ST_IDLE;
            end
        endcase
        if (selN) begin
            state_nxt = ST_IDLE;
        end
    end

    always @(posedge clk) begin
        if (!rst_n) begin
            state_r   <= ST_IDLE;
            prevClk_r <= 1'b1;
            prevSel_r <= 1'b1;
        end else begin
            state_r   <= state_nxt;
            prevClk_r <= sclk;
            prevSel_r <= selN;
        end
    end

    always @(posedge clk) begin
        if (!rst_n || selRise) begin
            bitCnt_r  <= 5'd0;
            readOp_r  <= 1'b0;
            addr_r    <= 7'h00;
            rxShift_r <= 8'h00;
        end else if (clkFall && state_r != ST_DONE && state_r != ST_IDLE) begin
            bitCnt_r  <= bitCnt_r + 5'd1;
            rxShift_r <= {rxShift_r[6:0], sdin};
            if (bitCnt_r == 5'd0) begin
                readOp_r <= sdin;
            end else if (bitCnt_r < `HEAD_BITS) begin
                addr_r <= {addr_r[5:0], sdin};
            end
        end
    end

    // Read word is loaded once the address is complete, then shifted on
    // each rising clock; a sync delay of a few clk cycles is well inside
    // the half period of the serial clock
    always @(posedge clk) begin
        if (!rst_n || selN) begin
            txShift_r <= 8'h00;
            dout_r    <= 1'b0;
        end else if (state_r == ST_HEAD && state_nxt == ST_DATA &&
                     readOp_r) begin
            txShift_r <= readWord;
        end else if (clkRise && state_r == ST_DATA && readOp_r) begin
            dout_r    <= txShift_r[7];
            txShift_r <= {txShift_r[6:0], 1'b0};
        end
    end

    assign dacSerialOut = dout_r;

    // The word is loaded on the edge that samples the last address bit,
    // so the address is completed here with the bit being sampled
    always @* begin
        case ({addr_r[5:0], sdin})
            `ADDR_POWER:         readWord = power_r;
            `ADDR_LEFT_LINE_IN:  readWord = leftGain_r;
            `ADDR_RIGHT_LINE_IN: readWord = rightGain_r;
            `ADDR_MIXER:         readWord = mixer_r;
            `ADDR_CLOCK_RATE:    readWord = clockRate_r;
            `ADDR_MISC:          readWord = misc_r;
            `ADDR_AUX_GAIN:      readWord = auxGain_r;
            default:             readWord = 8'h00;
        endcase
    end

    // Writes commit only on the sixteenth sampled bit of a write access
    assign wrStb  = clkFall && state_r == ST_DATA &&
                    bitCnt_r == `LAST_BIT && !readOp_r;
    assign wrData = {rxShift_r[6:0], sdin};

    always @(posedge clk) begin
        if (!rst_n) begin
            power_r     <= `RST_POWER;
            leftGain_r  <= `RST_LINE_IN;
            rightGain_r <= `RST_LINE_IN;
            mixer_r     <= `RST_MIXER;
            clockRate_r <= `RST_CLOCK_RATE;
            misc_r      <= `RST_MISC;
            auxGain_r   <= `RST_AUX_GAIN;
        end else if (wrStb) begin
            case (addr_r)
                `ADDR_POWER:
                    power_r <= wrData & `MASK_POWER;
                `ADDR_LEFT_LINE_IN:
                    leftGain_r <= wrData & `MASK_GAIN5;
                `ADDR_RIGHT_LINE_IN:
                    rightGain_r <= wrData & `MASK_GAIN5;
                `ADDR_MIXER:
                    mixer_r <= wrData & `MASK_MIXER;
                `ADDR_CLOCK_RATE:
                    clockRate_r <= wrData & `MASK_CLOCK_RATE;
                `ADDR_MISC:
                    misc_r <= wrData & `MASK_MISC;
                `ADDR_AUX_GAIN:
                    auxGain_r <= wrData & `MASK_GAIN5;
                default: begin
                end
            endcase
        end
    end

    // Decoded settings, registered so every output leaves a flip-flop
    always @(posedge clk) begin
        if (!rst_n) begin
            auxDb_r     <= 8'h00;
            auxFloor_r  <= 1'b0;
            leftHalf_r  <= 1'b0;
            rightHalf_r <= 1'b0;
            ratio_r     <= `RATIO_256;
            bits_r      <= 5'd16;
            fmtOneHot_r <= 3'b001;
        end else begin
            auxDb_r     <= gainToDb(auxGain_r[4:0]);
            auxFloor_r  <= auxGain_r[4:0] > `GAIN_LAST_CODE;
            leftHalf_r  <= mixer_r[`MIX_LEFT_LEFT] &
                           mixer_r[`MIX_LEFT_RIGHT];
            rightHalf_r <= mixer_r[`MIX_RIGHT_LEFT] &
                           mixer_r[`MIX_RIGHT_RIGHT];
            ratio_r     <= clockRate_r[`OVERSAMPLE_BIT] ?
                           `RATIO_384 : `RATIO_256;
            case (misc_r[`WIDTH_HI:`WIDTH_LO])
                `WIDTH_16: bits_r <= 5'd16;
                `WIDTH_18: bits_r <= 5'd18;
                `WIDTH_20: bits_r <= 5'd20;
                default:   bits_r <= 5'd20;
            endcase
            case (misc_r[`FORMAT_HI:`FORMAT_LO])
                `FORMAT_I2S: fmtOneHot_r <= 3'b001;
                `FORMAT_MSB: fmtOneHot_r <= 3'b010;
                default:     fmtOneHot_r <= 3'b100;
            endcase
        end
    end

    assign pwrMonoAmpDriver    = power_r[`PWR_MONO_AMP];
    assign pwrAuxInput         = power_r[`PWR_AUX_IN];
    assign pwrRightConverter   = power_r[`PWR_RIGHT_CONV];
    assign pwrLeftConverter    = power_r[`PWR_LEFT_CONV];
    assign pwrRightLineOut     = power_r[`PWR_RIGHT_LINE_OUT];
    assign pwrLeftLineOut      = power_r[`PWR_LEFT_LINE_OUT];
    assign pwrRightLineIn      = power_r[`PWR_RIGHT_LINE_IN];
    assign pwrLeftLineIn       = power_r[`PWR_LEFT_LINE_IN];
    assign leftLineInGainCode  = leftGain_r[4:0];
    assign rightLineInGainCode = rightGain_r[4:0];
    assign auxInputGain        = auxGain_r[4:0];
    assign auxGainDb           = auxDb_r;
    assign auxGainFloor        = auxFloor_r;
    assign leftMixLeftSrcEn    = mixer_r[`MIX_LEFT_LEFT];
    assign leftMixRightSrcEn   = mixer_r[`MIX_LEFT_RIGHT];
    assign rightMixLeftSrcEn   = mixer_r[`MIX_RIGHT_LEFT];
    assign rightMixRightSrcEn  = mixer_r[`MIX_RIGHT_RIGHT];
    assign leftMixHalfGain     = leftHalf_r;
    assign rightMixHalfGain    = rightHalf_r;
    assign oversampleRatioSel  = clockRate_r[`OVERSAMPLE_BIT];
    assign masterClockRatio    = ratio_r;
    assign sampleWidthSel      = misc_r[`WIDTH_HI:`WIDTH_LO];
    assign sampleBits          = bits_r;
    assign audioFormatSel      = misc_r[`FORMAT_HI:`FORMAT_LO];
    assign formatI2s           = fmtOneHot_r[0];
    assign formatMsbJustified  = fmtOneHot_r[1];
    assign formatLsbJustified  = fmtOneHot_r[2];
    assign deemphasisOn        = misc_r[`DEEMPH_BIT];
    assign ditherOn            = misc_r[`DITHER_BIT];
    assign sfrRdata            = sfrRdata_r;

endmodule

`default_nettype wire

// ==== test/core_model.sv ====
/*
 * Model of the controlling core: bit-bangs the converter serial port
 * through writes to the auxiliary pin control register.
 * Assumes the bench loops the pin outputs back onto the serial pins.
 */
`timescale 1ns/1ps
`default_nettype none

module core_model (
    input  wire logic       clk,
    input  wire logic [7:0] sfrRdata,
    output var  logic       sfrWrEn,
    output var  logic [7:0] sfrAddr,
    output var  logic [7:0] sfrWdata
);
    initial begin
        sfrWrEn = 1'b0;
        sfrAddr = 8'h90;
        sfrWdata = 8'hff;
    end

    // Each pin level stands 8 clocks, so the serial clock runs at 160 ns
    task automatic put(input logic d, input logic c, input logic s);
        @(posedge clk) #1 sfrWrEn = 1'b1;
        sfrWdata = {4'hf, d, c, s, 1'b1};
        @(posedge clk) #1 sfrWrEn = 1'b0;
        repeat (6) @(posedge clk);
    endtask

    // Data changes while the clock is high; read bits are taken late in
    // the low phase because the pin round trip costs about ten clocks
    task automatic xfer(input logic rd, input logic [6:0] a,
                        input logic [7:0] wd, input int n,
                        output logic [7:0] q);
        logic [15:0] w;
        w = {rd, a, wd};
        q = 8'h00;
        for (int i = 15; i > 15 - n; i--) begin
            put(w[i], 1'b1, 1'b0);
            put(w[i], 1'b0, 1'b0);
            #1;
            if (i < 8)
                q = {q[6:0], sfrRdata[4]};
        end
        put(1'b1, 1'b1, 1'b1);
    endtask
endmodule

`default_nettype wire

// ==== test/audio_dac_config_regs_assertions.sv ====
/*
 * Concurrent checks on the converter configuration bank.
 * Assumes it is bound into the top module and sees only its ports.
 */
`timescale 1ns/1ps
`default_nettype none

module dac_cfg_checker (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic       sfrWrEn,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic       auxPinClock,
    input wire logic       auxPinToDac,
    input wire logic       auxPinSelectN,
    input wire logic       dacSelectN,
    input wire logic       dacSerialOut,
    input wire logic [4:0] leftLineInGainCode,
    input wire logic [4:0] auxInputGain,
    input wire logic [7:0] auxGainDb,
    input wire logic       leftMixLeftSrcEn,
    input wire logic       leftMixRightSrcEn,
    input wire logic       rightMixLeftSrcEn,
    input wire logic       rightMixRightSrcEn,
    input wire logic       leftMixHalfGain,
    input wire logic       rightMixHalfGain,
    input wire logic       oversampleRatioSel,
    input wire logic [8:0] masterClockRatio,
    input wire logic [1:0] sampleWidthSel,
    input wire logic [4:0] sampleBits,
    input wire logic [1:0] audioFormatSel,
    input wire logic       formatI2s,
    input wire logic       formatMsbJustified,
    input wire logic       formatLsbJustified
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_reset_state: assert property ($rose(rst_n) |->
        {auxPinToDac, auxPinClock, auxPinSelectN} == 3'b111
        && leftLineInGainCode == 5'h05)
        else $error("reset state wrong");
    a_aux_write: assert property (sfrWrEn && sfrAddr == 8'h90 |=>
        {auxPinToDac, auxPinClock, auxPinSelectN} == $past(sfrWdata[3:1]))
        else $error("aux pins do not follow the write");
    a_aux_hold: assert property (!(sfrWrEn && sfrAddr == 8'h90) |=>
        $stable({auxPinToDac, auxPinClock, auxPinSelectN}))
        else $error("aux pins moved without a write");
    a_idle_out: assert property (dacSelectN [*8] |-> !dacSerialOut)
        else $error("serial out active while deselected");
    a_left_half: assert property (leftMixHalfGain ==
        $past(leftMixLeftSrcEn && leftMixRightSrcEn))
        else $error("left mixer attenuation wrong");
    a_right_half: assert property (rightMixHalfGain ==
        $past(rightMixLeftSrcEn && rightMixRightSrcEn))
        else $error("right mixer attenuation wrong");
    a_clock_ratio: assert property (masterClockRatio ==
        ($past(oversampleRatioSel) ? 9'd384 : 9'd256))
        else $error("master clock ratio wrong");
    a_sample_width: assert property (sampleBits ==
        ($past(sampleWidthSel) == 2'b00 ? 5'd16 :
         $past(sampleWidthSel) == 2'b01 ? 5'd18 : 5'd20))
        else $error("sample width wrong");
    a_format_sel: assert property (
        {formatI2s, formatMsbJustified, formatLsbJustified} ==
        {$past(audioFormatSel) == 2'b00, $past(audioFormatSel) == 2'b01,
         $past(audioFormatSel[1])})
        else $error("format decode wrong");
    a_aux_gain: assert property (auxGainDb ==
        ($past(auxInputGain) == 5'h00 ? 8'h14 :
         $past(auxInputGain) <= 5'h10 ?
         8'h0f - 8'h03 * {3'h0, $past(auxInputGain)} : 8'hc4))
        else $error("aux gain decode wrong");

    c_aux_write: cover property (sfrWrEn && sfrAddr == 8'h90);
    c_half_gain: cover property ($rose(leftMixHalfGain));
    c_ratio_384: cover property (masterClockRatio == 9'd384);
endmodule

bind audio_dac_config_regs dac_cfg_checker chk_u (
    .clk, .rst_n, .sfrWrEn, .sfrAddr, .sfrWdata, .auxPinClock,
    .auxPinToDac, .auxPinSelectN, .dacSelectN, .dacSerialOut,
    .leftLineInGainCode, .auxInputGain, .auxGainDb, .leftMixLeftSrcEn,
    .leftMixRightSrcEn, .rightMixLeftSrcEn, .rightMixRightSrcEn,
    .leftMixHalfGain, .rightMixHalfGain, .oversampleRatioSel,
    .masterClockRatio, .sampleWidthSel, .sampleBits, .audioFormatSel,
    .formatI2s, .formatMsbJustified, .formatLsbJustified);

`default_nettype wire

// ==== test/tb.sv ====
/*
 * Self-checking bench: serial register accesses made by the core model.
 * Assumes the auxiliary pins are looped onto the serial pins here.
 */
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic       clk;
    logic       rst_n;
    logic [4:0] c;
    logic [7:0] e;
    logic [7:0] q;
    wire        sfrWrEn;
    wire  [7:0] sfrAddr, sfrWdata, sfrRdata, pwr, auxGainDb;
    wire  [4:0] llGain, rlGain, auxInputGain, sampleBits;
    wire  [8:0] masterClockRatio;
    wire  [1:0] sampleWidthSel, audioFormatSel;
    wire  [3:0] mixEn;
    wire        auxPinClock, auxPinToDac, auxPinSelectN, dacSerialOut;
    wire        auxGainFloor, lHalf, rHalf, ovs, fI2s, fMsb, fLsb;
    wire        deem, dith;
    int         n_mismatch = 0;
    int         checks_done = 0;
    logic [4:0] codes [6] = '{5'h00, 5'h01, 5'h05, 5'h10, 5'h11, 5'h1f};

    core_model cm (.clk(clk), .sfrRdata(sfrRdata), .sfrWrEn(sfrWrEn),
        .sfrAddr(sfrAddr), .sfrWdata(sfrWdata));

    audio_dac_config_regs dut_u (.clk(clk), .rst_n(rst_n),
        .sfrWrEn(sfrWrEn), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrRdata(sfrRdata), .auxPinClock(auxPinClock),
        .auxPinToDac(auxPinToDac), .auxPinSelectN(auxPinSelectN),
        .auxPinFromDac(dacSerialOut), .dacSerialClock(auxPinClock),
        .dacSerialIn(auxPinToDac), .dacSelectN(auxPinSelectN),
        .dacSerialOut(dacSerialOut), .pwrMonoAmpDriver(pwr[7]),
        .pwrAuxInput(pwr[6]), .pwrRightConverter(pwr[5]),
        .pwrLeftConverter(pwr[4]), .pwrRightLineOut(pwr[3]),
        .pwrLeftLineOut(pwr[2]), .pwrRightLineIn(pwr[1]),
        .pwrLeftLineIn(pwr[0]), .leftLineInGainCode(llGain),
        .rightLineInGainCode(rlGain), .auxInputGain(auxInputGain),
        .auxGainDb(auxGainDb), .auxGainFloor(auxGainFloor),
        .leftMixLeftSrcEn(mixEn[0]), .leftMixRightSrcEn(mixEn[1]),
        .rightMixLeftSrcEn(mixEn[2]), .rightMixRightSrcEn(mixEn[3]),
        .leftMixHalfGain(lHalf), .rightMixHalfGain(rHalf),
        .oversampleRatioSel(ovs), .masterClockRatio(masterClockRatio),
        .sampleWidthSel(sampleWidthSel), .sampleBits(sampleBits),
        .audioFormatSel(audioFormatSel), .formatI2s(fI2s),
        .formatMsbJustified(fMsb), .formatLsbJustified(fLsb),
        .deemphasisOn(deem), .ditherOn(dith));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic check(input logic [8:0] seen, input logic [8:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: saw %h, expected %h",
                     $time, seen, exp);
        end
    endtask

    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        logic [7:0] r;
        cm.xfer(1'b0, a, d, 16, r);
    endtask

    // Master data bits of a read are not meaningful; send a pattern
    task automatic rd(input logic [6:0] a, input logic [7:0] x);
        logic [7:0] r;
        cm.xfer(1'b1, a, ~x, 16, r);
        check({1'b0, r}, {1'b0, x});
    endtask

    task automatic finish_test();
        $display("checks %0d, mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    initial begin
        #300000;
        n_mismatch++;
        finish_test();
    end

    initial begin
        rst_n = 1'b0;
        repeat (11) @(posedge clk);
        #1 check({1'b0, sfrRdata}, 9'h0ff);
        check({6'h0, auxPinToDac, auxPinClock, auxPinSelectN},
              9'h7);
        check({1'b0, pwr}, 9'h000);
        @(posedge clk) #1 rst_n = 1'b1;
        rd(7'h00, 8'h00);
        rd(7'h01, 8'h05);
        rd(7'h02, 8'h05);
        $display("reset values done");
        wr(7'h00, 8'ha5);
        rd(7'h00, 8'ha5);
        check({1'b0, pwr}, 9'h0a5);
        wr(7'h00, 8'h5a);
        check({1'b0, pwr}, 9'h05a);
        wr(7'h01, 8'hff);
        rd(7'h01, 8'h1f);
        wr(7'h02, 8'he3);
        rd(7'h02, 8'h03);
        check({4'h0, rlGain}, 9'h003);
        wr(7'h7f, 8'h55);
        rd(7'h7f, 8'h00);
        $display("register access done");
        cm.xfer(1'b0, 7'h01, 8'h0a, 12, q);
        rd(7'h01, 8'h1f);
        check({4'h0, llGain}, 9'h01f);
        $display("aborted access done");
        for (int v = 0; v < 16; v++) begin
            wr(7'h08, 8'(v));
            check({5'h0, mixEn}, 9'(v));
            check({7'h0, rHalf, lHalf},
                  {7'h0, v[3:2] == 2'b11, v[1:0] == 2'b11});
        end
        $display("mixer done");
        for (int i = 0; i < 2; i++) begin
            wr(7'h09, {3'h0, i[0], 4'h0});
            check(masterClockRatio, i[0] ? 9'd384 : 9'd256);
            check({8'h0, ovs}, {8'h0, i[0]});
        end
        for (int i = 0; i < 4; i++) begin
            wr(7'h0a, {2'h0, i[1:0], i[0], i[1], i[1:0]});
            check({4'h0, sampleBits},
                  9'(i == 0 ? 16 : i == 1 ? 18 : 20));
            check({6'h0, fI2s, fMsb, fLsb},
                  {6'h0, i == 0, i == 1, i[1]});
            check({7'h0, deem, dith}, {7'h0, i[1], i[0]});
            check({5'h0, audioFormatSel, sampleWidthSel},
                  {5'h0, i[1:0], i[1:0]});
        end
        $display("clock and format done");
        for (int k = 0; k < 6; k++) begin
            c = codes[k];
            e = (c == 5'h00) ? 8'h14 :
                (c <= 5'h10) ? 8'h0f - 8'h03 * {3'h0, c} : 8'hc4;
            wr(7'h0d, {3'h0, c});
            check({1'b0, auxGainDb}, {1'b0, e});
            check({4'h0, auxInputGain}, {4'h0, c});
            check({8'h0, auxGainFloor}, {8'h0, c > 5'h10});
        end
        $display("aux gain done");
        finish_test();
    end
endmodule

`default_nettype wire
